// ### pkg/frame_pkg.sv
// Purpose: constants and types for the quad converter frame decoder
// Assumes: 24-bit frames, MSB first, one frame per sync window
// Notes: channel registers are reached only through the serial frame
// Summary of operation
// [RULE1] Each frame is 24 bits, shifted in MSB first on serial data.
// [RULE2] Bit 23 selects read or write of the addressed register.
// [RULE3] Host always sends bit 22 as zero.
// [RULE4] Bits 21..19 select code, range, power or control register.
// [RULE5] Bits 18..16 select channel A..D, or 100 for all four.
// [RULE6] Bits 15..0 carry the 16-bit payload.
// [RULE7] Select 000 writes payload into chosen channel code register(s).
// [RULE8] 16-bit variant keeps payload bits 15..0 as the code.
// [RULE9] 14-bit variant keeps bits 15..2, low two ignored.
// [RULE10] 12-bit variant keeps bits 15..4, low four ignored.
// [RULE11] Select 001 stores payload bits 2..0 as channel range code.
// [RULE12] Range codes 000..101 give the six documented full-scale ranges.
// [RULE13] Every frame-reachable register can be written and read back.
// [RULE14] Act only after 24 bits; range codes 110 and 111 are ignored.
package frame_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 16;
  localparam int RANGE_W = 3;
  localparam logic [2:0] SEL_CODE = 3'h0;
  localparam logic [2:0] SEL_RANGE = 3'h1;
  localparam logic [2:0] SEL_POWER = 3'h2;
  localparam logic [2:0] SEL_CTRL = 3'h3;
  localparam logic [2:0] ADDR_ALL = 3'h4;
  localparam logic [2:0] RANGE_MAX = 3'h5;
  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Unipolar 5, 10, 10.8 V then bipolar 5, 10, 10.8 V
  typedef enum logic [2:0] {
    RANGE_UNI_5, RANGE_UNI_10, RANGE_UNI_10P8,
    RANGE_BI_5, RANGE_BI_10, RANGE_BI_10P8
  } range_t;

  typedef struct packed {
    logic read_not_write;
    logic reserved_zero;
    logic [2:0] regsel;
    logic [2:0] chan_addr;
    logic [15:0] payload;
  } frame_t;
endpackage

// ### testbench/frame_host.sv
// Purpose: host serial port model driving frames into the decoder
// Assumes: 64 ns serial clock period, data changed while sclk high
// Notes: sclk parked high between frames; data flips when idle
module frame_host (
  output logic sync_n,
  output logic sclk,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    serial_data_in = 1'b0;
  end

  // ****************************************
  // Frame transmit, nbits < 24 cuts it short
  // ****************************************
  task automatic send(input logic [23:0] word, input int nbits);
    sync_n <= 1'b0;
    #32;
    for (int i = 23; i > 23 - nbits; i--) begin
      serial_data_in <= word[i];
      #32 sclk <= 1'b0;
      #32 sclk <= 1'b1;
    end
    #32 sync_n <= 1'b1;
    // Idle line must not keep the last bit alive
    serial_data_in <= ~serial_data_in;
  endtask
endmodule

// ### testbench/quad_dac_frame_decoder_test.sv
// Purpose: self-checking bench for the frame decoder, three resolutions
// Assumes: one host model shared by all three decoders
// Notes: bits below resolution expected to read back as zero
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fails++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module quad_dac_frame_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import frame_pkg::*;
  logic clk, sys_rst, sync_n, sclk, sdi, rv, re;
  logic [63:0] code16, code14, code12;
  logic [11:0] range16;
  logic [15:0] pw, cw, rd, got_rd, pl;
  bit seen_rv, seen_re;
  int fails = 0;
  int n_compared = 0;
  frame_t f;

  frame_host host (.sync_n(sync_n), .sclk(sclk), .serial_data_in(sdi));
  quad_dac_frame_decoder #(.RESOLUTION(16)) dut (.clk(clk),
    .sys_rst(sys_rst), .sync_n(sync_n), .sclk(sclk),
    .serial_data_in(sdi), .code_flat(code16), .range_flat(range16),
    .power_word(pw), .control_word(cw), .read_data(rd),
    .read_valid(rv), .reserved_error(re));
  quad_dac_frame_decoder #(.RESOLUTION(14)) dut14 (.clk(clk),
    .sys_rst(sys_rst), .sync_n(sync_n), .sclk(sclk),
    .serial_data_in(sdi), .code_flat(code14), .range_flat(),
    .power_word(), .control_word(), .read_data(), .read_valid(),
    .reserved_error());
  quad_dac_frame_decoder #(.RESOLUTION(12)) dut12 (.clk(clk),
    .sys_rst(sys_rst), .sync_n(sync_n), .sclk(sclk),
    .serial_data_in(sdi), .code_flat(code12), .range_flat(),
    .power_word(), .control_word(), .read_data(), .read_valid(),
    .reserved_error());

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulses last one cycle, so catch them as they pass
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      seen_rv = 1;
      got_rd = rd;
    end
    if (re === 1'b1) seen_re = 1;
  end

  function automatic frame_t mk(logic rw, logic [2:0] sel,
      logic [2:0] ad, logic [15:0] p);
    mk = '{rw, 1'b0, sel, ad, p};
  endfunction

  task automatic xfer(input frame_t fr, input int nbits = 24);
    seen_rv = 0;
    seen_re = 0;
    host.send(fr, nbits);
    repeat (10) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("code reset", 64'h0, code16)
    for (int c = 0; c < 4; c++) begin
      pl = {4{c[3:0]}} ^ 16'h9E37;
      xfer(mk(1'b0, SEL_CODE, c[2:0], pl));
      `CHK("code16", pl, code16[c*16+:16])
      `CHK("code14", pl & 16'hFFFC, code14[c*16+:16])
      `CHK("code12", pl & 16'hFFF0, code12[c*16+:16])
    end
    xfer(mk(1'b0, SEL_CODE, ADDR_ALL, 16'hC3A9));
    `CHK("code all", {4{16'hC3A9}}, code16)
    xfer(mk(1'b0, SEL_CODE, 3'h5, 16'hFFFF));
    `CHK("bad addr", {4{16'hC3A9}}, code16)
    xfer(mk(1'b1, SEL_CODE, 3'h2, 16'h0000));
    `CHK("read pulse", 1'b1, seen_rv)
    `CHK("read code", 16'hC3A9, got_rd)
    `CHK("no write", 16'hC3A9, code16[47:32])
    `CHK("no reserved", 1'b0, seen_re)
    xfer(mk(1'b1, SEL_CODE, 3'h6, 16'h0000));
    `CHK("read bad addr", 1'b0, seen_rv)
    for (int r = 0; r < 6; r++) begin
      xfer(mk(1'b0, SEL_RANGE, 3'h1, {13'h1FFF, r[2:0]}));
      `CHK("range", r[2:0], range16[5:3])
    end
    xfer(mk(1'b0, SEL_RANGE, 3'h1, 16'h0006));
    `CHK("range undef", 3'h5, range16[5:3])
    xfer(mk(1'b0, SEL_RANGE, ADDR_ALL, 16'h0003));
    `CHK("range all", 12'h6DB, range16)
    xfer(mk(1'b1, SEL_RANGE, 3'h0, 16'h0000));
    `CHK("read range", 16'h0003, got_rd)
    xfer(mk(1'b0, SEL_POWER, 3'h0, 16'h078F));
    `CHK("power", 16'h078F, pw)
    xfer(mk(1'b0, SEL_CTRL, 3'h1, 16'h000D));
    `CHK("control", 16'h000D, cw)
    xfer(mk(1'b1, SEL_CTRL, 3'h1, 16'h0000));
    `CHK("read ctrl", 16'h000D, got_rd)
    xfer(mk(1'b1, SEL_POWER, 3'h0, 16'h0000));
    `CHK("read power", 16'h078F, got_rd)
    xfer(mk(1'b0, SEL_CODE, 3'h0, 16'h5555), 12);
    `CHK("partial", 16'hC3A9, code16[15:0])
    f = mk(1'b0, SEL_CODE, 3'h3, 16'h0F0F);
    f.reserved_zero = 1'b1;
    xfer(f);
    `CHK("reserved", 1'b1, seen_re)
    `CHK("after", 16'h0F0F, code16[63:48])
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("reset code", 64'h0, code16)
    `CHK("reset ctrl", 16'h0000, cw)
    give_verdict();
  end

  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule

// ### verilog/frame_shifter.sv
// Purpose: collect one 24-bit frame from synchronised serial pins
// Assumes: sync, clock and data already passed two flip-flops
// Notes: a frame cut short by sync rising is dropped whole
module frame_shifter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sync_n_s,
  input wire logic sclk_s,
  input wire logic serial_data_in_s,
  output frame_pkg::frame_t frame,
  output logic frame_done
);
  import frame_pkg::*;

  logic sclk_d;
  logic [CNT_W-1:0] count;
  logic [FRAME_BITS-1:0] shift;
  logic fall;

  // Data is taken on the falling serial clock edge
  assign fall = sclk_d & ~sclk_s & ~sync_n_s;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      shift <= '0;
      frame_done <= 1'b0;
      frame <= '0;
    end else begin
      frame_done <= 1'b0;
      if (sync_n_s) begin
        count <= '0;
      end else if (fall) begin
        shift <= {shift[FRAME_BITS-2:0], serial_data_in_s}; // [RULE1]
        if (count == LAST_BIT) begin
          frame <= frame_t'({shift[FRAME_BITS-2:0], serial_data_in_s});
          frame_done <= 1'b1; // [RULE14]
          count <= '0;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule

// ### verilog/quad_dac_frame_decoder.sv
// Purpose: decode serial frames into per-channel code and range registers
// Assumes: host keeps the reserved bit zero
// Notes: readback word is presented on a parallel port after a read frame
module quad_dac_frame_decoder #(
  parameter int RESOLUTION = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  output logic [frame_pkg::NUM_CH*frame_pkg::DATA_W-1:0] code_flat,
  output logic [frame_pkg::NUM_CH*frame_pkg::RANGE_W-1:0] range_flat,
  output logic [frame_pkg::DATA_W-1:0] power_word,
  output logic [frame_pkg::DATA_W-1:0] control_word,
  output logic [frame_pkg::DATA_W-1:0] read_data,
  output logic read_valid,
  output logic reserved_error
);
  import frame_pkg::*;

  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= '1;
      pin_sync <= '1;
    end else begin
      pin_meta <= {sync_n, sclk, serial_data_in};
      pin_sync <= pin_meta;
    end
  end

  frame_t frame;
  logic frame_done;

  frame_shifter u_shift (
    .clk(clk),
    .sys_rst(sys_rst),
    .sync_n_s(pin_sync[2]),
    .sclk_s(pin_sync[1]),
    .serial_data_in_s(pin_sync[0]),
    .frame(frame),
    .frame_done(frame_done)
  );

  // ****************************************
  // Decode helpers
  // ****************************************
  // Low payload bits beyond the resolution are dropped
  function automatic logic [DATA_W-1:0] trim_code(
    input logic [DATA_W-1:0] p
  );
    logic [DATA_W-1:0] mask;
    mask = '1;
    mask = mask << (DATA_W - RESOLUTION); // [RULE8] [RULE9] [RULE10]
    return p & mask;
  endfunction

  function automatic logic hits(
    input logic [2:0] addr,
    input int ch
  );
    return (addr == ADDR_ALL) || (addr == 3'(ch)); // [RULE5]
  endfunction

  logic is_write;
  logic [2:0] sel;
  logic [2:0] addr;
  logic [DATA_W-1:0] payload;
  logic addr_ok;

  assign is_write = ~frame.read_not_write; // [RULE2]
  assign sel = frame.regsel; // [RULE4]
  assign addr = frame.chan_addr;
  assign payload = frame.payload; // [RULE6]
  assign addr_ok = (addr == ADDR_ALL) || (addr < 3'(NUM_CH));

  // ****************************************
  // Channel registers
  // ****************************************
  logic [DATA_W-1:0] code [NUM_CH];
  logic [RANGE_W-1:0] range_reg [NUM_CH];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        code[i] <= CODE_RESET;
      end
    end else if (frame_done && is_write && sel == SEL_CODE) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hits(addr, i)) begin
          code[i] <= trim_code(payload); // [RULE7]
        end
      end
    end
  end

  // Codes above 101 leave the range untouched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        range_reg[i] <= RANGE_RESET;
      end
    end else if (frame_done && is_write && sel == SEL_RANGE &&
                 payload[RANGE_W-1:0] <= RANGE_MAX) begin // [RULE14]
      for (int i = 0; i < NUM_CH; i++) begin
        if (hits(addr, i)) begin
          range_reg[i] <= payload[RANGE_W-1:0]; // [RULE11] [RULE12]
        end
      end
    end
  end

  // Power and control words held raw; their fields live elsewhere
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_word <= WORD_RESET;
      control_word <= WORD_RESET;
    end else if (frame_done && is_write) begin
      if (sel == SEL_POWER) begin
        power_word <= payload;
      end
      if (sel == SEL_CTRL) begin
        control_word <= payload;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_flat <= '0;
      range_flat <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        code_flat[i*DATA_W +: DATA_W] <= code[i];
        range_flat[i*RANGE_W +: RANGE_W] <= range_reg[i];
      end
    end
  end

  // ****************************************
  // Readback
  // ****************************************
  // All-channels read returns channel A, a single word is all we can show
  logic [1:0] rd_ch;
  assign rd_ch = (addr == ADDR_ALL) ? 2'h0 : addr[1:0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_data <= '0;
      read_valid <= 1'b0;
    end else begin
      read_valid <= frame_done && !is_write && addr_ok;
      if (frame_done && !is_write) begin
        unique case (sel)
          SEL_CODE: read_data <= code[rd_ch]; // [RULE13]
          SEL_RANGE: read_data <= DATA_W'(range_reg[rd_ch]); // [RULE13]
          SEL_POWER: read_data <= power_word; // [RULE13]
          SEL_CTRL: read_data <= control_word; // [RULE13]
          default: read_data <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reserved_error <= 1'b0;
    end else begin
      reserved_error <= frame_done && frame.reserved_zero; // [RULE3]
    end
  end

  // ****************************************
  // Write checks
  // ****************************************
  chk_code_all_write: assert property ( // [RULE7]
    frame_done && is_write && sel == SEL_CODE && addr == ADDR_ALL
    |=> code[3] == trim_code($past(payload)))
    else $error("all-channel code write lost");

  chk_code_single_write: assert property ( // [RULE7]
    frame_done && is_write && sel == SEL_CODE && addr == 3'h0
    |=> code[0] == trim_code($past(payload)))
    else $error("channel A code write lost");

  chk_code_flat_lag: assert property ( // [RULE5]
    frame_done && is_write && sel == SEL_CODE && addr == 3'h1
    |=> ##1 code_flat[2*DATA_W-1:DATA_W] == trim_code($past(payload, 2)))
    else $error("channel B output mismatch");

  chk_code_other_ch: assert property ( // [RULE5]
    frame_done && sel == SEL_CODE && addr == 3'h1
    |=> $stable(code[0]) && $stable(code[2]))
    else $error("write leaked to another channel");

  chk_code_bad_addr: assert property ( // [RULE5]
    frame_done && !addr_ok
    |=> $stable(code[0]) && $stable(code[3]) && $stable(range_reg[0]))
    else $error("unused address changed a channel");

  chk_code_trim: assert property ( // [RULE8] [RULE9] [RULE10]
    code[0] == trim_code(code[0]) && code[3] == trim_code(code[3]))
    else $error("ignored code bits stored");

  chk_power_write: assert property ( // [RULE4]
    frame_done && is_write && sel == SEL_POWER
    |=> power_word == $past(payload))
    else $error("power word write lost");

  chk_ctrl_write: assert property ( // [RULE4]
    frame_done && is_write && sel == SEL_CTRL
    |=> control_word == $past(payload))
    else $error("control word write lost");

  // ****************************************
  // Range checks
  // ****************************************
  chk_range_bad: assert property ( // [RULE14]
    frame_done && sel == SEL_RANGE && payload[2:0] > RANGE_MAX
    |=> $stable(range_reg[0]))
    else $error("illegal range stored");

  chk_range_write: assert property ( // [RULE11]
    frame_done && is_write && sel == SEL_RANGE && addr == 3'h2 &&
    payload[2:0] <= RANGE_MAX
    |=> range_reg[2] == $past(payload[2:0]))
    else $error("range write lost");

  chk_range_all: assert property ( // [RULE11]
    frame_done && is_write && sel == SEL_RANGE && addr == ADDR_ALL &&
    payload[2:0] <= RANGE_MAX
    |=> range_reg[1] == $past(payload[2:0]) &&
    range_reg[3] == $past(payload[2:0]))
    else $error("all-channel range write lost");

  chk_range_legal: assert property ( // [RULE12]
    range_reg[0] <= RANGE_BI_10P8 && range_reg[3] <= RANGE_BI_10P8)
    else $error("undefined range code held");

  chk_range_flat: assert property ( // [RULE11]
    range_flat[RANGE_W-1:0] == $past(range_reg[0]))
    else $error("range output lags wrongly");

  // ****************************************
  // Readback checks
  // ****************************************
  chk_read_no_write: assert property ( // [RULE2]
    frame_done && !is_write |=> $stable(power_word) && $stable(code[0]))
    else $error("read frame changed state");

  chk_read_back: assert property ( // [RULE13]
    frame_done && !is_write && sel == SEL_CTRL
    |=> read_valid && read_data == control_word)
    else $error("control readback wrong");

  chk_read_code: assert property ( // [RULE13]
    frame_done && !is_write && sel == SEL_CODE && addr == 3'h2
    |=> read_data == code[2])
    else $error("code readback wrong");

  chk_read_range: assert property ( // [RULE13]
    frame_done && !is_write && sel == SEL_RANGE && addr == 3'h0
    |=> read_data == DATA_W'(range_reg[0]))
    else $error("range readback wrong");

  chk_read_power: assert property ( // [RULE13]
    frame_done && !is_write && sel == SEL_POWER
    |=> read_data == power_word)
    else $error("power readback wrong");

  chk_read_bad_addr: assert property ( // [RULE5]
    frame_done && !is_write && !addr_ok |=> !read_valid)
    else $error("read of unused address flagged valid");

  chk_read_pulse: assert property ( // [RULE13]
    read_valid |=> !read_valid)
    else $error("read valid longer than a cycle");

  chk_read_hold: assert property ( // [RULE13]
    !frame_done |=> $stable(read_data))
    else $error("read word changed between frames");

  // ****************************************
  // Frame checks
  // ****************************************
  chk_only_on_frame: assert property ( // [RULE14]
    !frame_done |=> $stable(control_word) && $stable(range_reg[1]))
    else $error("update outside frame end");

  chk_done_pulse: assert property ( // [RULE14]
    frame_done |=> !frame_done)
    else $error("frame end held longer than a cycle");

  chk_reserved_flag: assert property ( // [RULE3]
    frame_done && frame.reserved_zero |=> reserved_error)
    else $error("reserved bit not flagged");

  chk_reserved_quiet: assert property ( // [RULE3]
    !frame_done |=> !reserved_error)
    else $error("reserved flag without a frame");
endmodule
